/* File: src/eps_pkg.sv */
// Constants and carrier types for the host serial port of the display controller.
// Assumes a single core clock domain; all link pins are asynchronous to it.
//
// Function
// (RL1) Ignore link traffic while chip select high.
// (RL2) Four-wire: select high marks a data byte.
// (RL3) Four-wire: select low marks a command byte.
// (RL4) Hardware reset low holds the port in reset.
// (RL5) Host waits for busy low before sending.
// (RL6) Busy high during waveform or sensor access.
// (RL7) Strap low: four-wire, eight bits, select line.
// (RL8) Strap high: three-wire, nine bits per unit.
// (RL9) Sample on rising edge, MSB first, eight bits.
// (RL10) Three-wire: select bit first, then byte MSB-first.
// (RL11) Read: shift result out on falling edges, MSB-first.
// (RL12) Chip select rise or reset discards partial byte.
package eps_pkg;

  localparam int BYTE_W = 8;
  localparam logic [3:0] LAST_BIT_4W = 4'h7;
  localparam logic [3:0] LAST_BIT_3W = 4'h8;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [2:0] TX_CNT_RST = 3'h0;
  localparam logic [8:0] SHIFT_RST = 9'h000;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef struct packed {
    logic cs_n;
    logic scl;
    logic sda;
    logic dc;
  } eps_link_t;

  typedef struct packed {
    logic is_data;
    logic [BYTE_W-1:0] data;
  } eps_word_t;

  localparam eps_link_t LINK_RST = '{cs_n: 1'b1, scl: 1'b0, sda: 1'b0, dc: 1'b0};
  localparam eps_word_t WORD_RST = '{is_data: 1'b0, data: 8'h00};

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RECV,
    ST_RDDC,
    ST_READ
  } eps_state_t;

endpackage

/* File: src/eps_buf.sv */
// Two-entry word buffer with valid/ready on both sides.
// Assumes both sides on MCLK; head entry is a register so the output needs no mux.
`timescale 1ns/100ps
`default_nettype none
module eps_buf (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire eps_pkg::eps_word_t in_word,
  output logic out_valid,
  input wire logic out_ready,
  output eps_pkg::eps_word_t out_word
);
  import eps_pkg::*;

  eps_word_t slot0_reg, slot0_next;
  eps_word_t slot1_reg, slot1_next;
  logic [1:0] cnt_reg, cnt_next;
  logic valid_reg, valid_next;
  logic push, pop;

  assign in_ready = (cnt_reg != BUF_DEPTH);
  // Valid has its own flop so the port output needs no decode
  assign out_valid = valid_reg;
  assign out_word = slot0_reg;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    slot0_next = slot0_reg;
    slot1_next = slot1_reg;
    cnt_next = cnt_reg;
    if (pop) begin
      slot0_next = slot1_reg;
    end
    if (push) begin
      if ((cnt_reg == 2'h0) || (pop && cnt_reg == 2'h1)) begin
        slot0_next = in_word;
      end else begin
        slot1_next = in_word;
      end
    end
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    valid_next = (cnt_next != 2'h0);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      slot0_reg <= WORD_RST;
      slot1_reg <= WORD_RST;
      cnt_reg <= 2'h0;
      valid_reg <= 1'b0;
    end else begin
      slot0_reg <= slot0_next;
      slot1_reg <= slot1_next;
      cnt_reg <= cnt_next;
      valid_reg <= valid_next;
    end
  end

endmodule
`default_nettype wire

/* File: src/eps_port.sv */
// Host serial port: receives commands and data, returns read bytes, drives busy.
// Assumes link pins are asynchronous to MCLK and the link clock is slow enough to oversample.
`timescale 1ns/100ps
`default_nettype none
module eps_port (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic HW_RESET_N,
  input wire logic BUS_MODE_STRAP,
  input wire eps_pkg::eps_link_t LINK,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic BUSY,
  input wire logic WAVE_ACTIVE,
  input wire logic TSENS_ACTIVE,
  input wire logic RD_EN,
  input wire logic [7:0] RD_DATA,
  output logic RD_TAKE,
  output logic RX_VALID,
  input wire logic RX_READY,
  output eps_pkg::eps_word_t RX_WORD
);
  import eps_pkg::*;

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  eps_link_t link_m_reg, link_s_reg;
  logic hwr_m_reg, hwr_s_reg, strap_m_reg, strap_s_reg, scl_d_reg;
  logic srst, rise, fall;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      link_m_reg <= LINK_RST;
      link_s_reg <= LINK_RST;
      hwr_m_reg <= 1'b0;
      hwr_s_reg <= 1'b0;
      strap_m_reg <= 1'b0;
      strap_s_reg <= 1'b0;
      scl_d_reg <= 1'b0;
    end else begin
      link_m_reg <= LINK;
      link_s_reg <= link_m_reg;
      hwr_m_reg <= HW_RESET_N;
      hwr_s_reg <= hwr_m_reg;
      strap_m_reg <= BUS_MODE_STRAP;
      strap_s_reg <= strap_m_reg;
      scl_d_reg <= link_s_reg.scl;
    end
  end

  assign srst = !RST_N || !hwr_s_reg; // RL4
  // Edges only count while selected
  assign rise = link_s_reg.scl && !scl_d_reg && !link_s_reg.cs_n; // RL1
  assign fall = !link_s_reg.scl && scl_d_reg && !link_s_reg.cs_n; // RL1

  // ==========================================================
  // Frame state, shifter and read-back
  // ==========================================================
  eps_state_t state_reg, state_next;
  logic mode3_reg, mode3_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [8:0] shift_reg, shift_next;
  logic [2:0] tx_cnt_reg, tx_cnt_next;
  logic [7:0] tx_reg, tx_next;
  logic sda_out_reg, sda_out_next, sda_oe_reg, sda_oe_next, rd_take_reg, rd_take_next;
  logic pend_reg, pend_next, buf_ready, complete;
  eps_word_t pend_word_reg, pend_word_next, word;

  always_comb begin
    state_next = state_reg;
    mode3_next = mode3_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_next = tx_reg;
    sda_out_next = sda_out_reg;
    sda_oe_next = sda_oe_reg;
    rd_take_next = 1'b0;
    complete = 1'b0;
    word = pend_word_reg;
    case (state_reg)
      ST_IDLE: begin
        cnt_next = BIT_CNT_RST;
        if (!link_s_reg.cs_n) begin
          state_next = ST_RECV;
          mode3_next = strap_s_reg; // RL7 RL8
        end
      end
      ST_RECV: begin
        if (rise) begin
          shift_next = {shift_reg[7:0], link_s_reg.sda}; // RL9
          if (cnt_reg == (mode3_reg ? LAST_BIT_3W : LAST_BIT_4W)) begin // RL7 RL8
            complete = 1'b1;
            cnt_next = BIT_CNT_RST;
            word.is_data = mode3_reg ? shift_next[8] : link_s_reg.dc; // RL2 RL3 RL10
            word.data = shift_next[7:0]; // RL9 RL10
            if (!word.is_data && RD_EN) begin
              state_next = mode3_reg ? ST_RDDC : ST_READ;
              tx_cnt_next = TX_CNT_RST;
            end
          end else begin
            cnt_next = cnt_reg + 4'h1;
          end
        end
      end
      ST_RDDC: begin
        // Three-wire read: one select bit precedes the result
        if (rise) begin
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        if (fall) begin
          sda_oe_next = 1'b1;
          tx_cnt_next = tx_cnt_reg + 3'h1;
          if (tx_cnt_reg == TX_CNT_RST) begin
            sda_out_next = RD_DATA[7]; // RL11
            tx_next = {RD_DATA[6:0], 1'b0};
            rd_take_next = 1'b1;
          end else begin
            sda_out_next = tx_reg[7]; // RL11
            tx_next = {tx_reg[6:0], 1'b0};
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Chip select rise drops any partial byte and releases the line
    if (link_s_reg.cs_n) begin
      state_next = ST_IDLE; // RL1 RL12
      cnt_next = BIT_CNT_RST; // RL12
      sda_oe_next = 1'b0;
    end
    pend_next = (pend_reg && !buf_ready) || complete;
    pend_word_next = complete ? word : pend_word_reg;
  end

  always_ff @(posedge MCLK) begin
    if (srst) begin
      state_reg <= ST_IDLE; // RL4 RL12
      mode3_reg <= 1'b0;
      cnt_reg <= BIT_CNT_RST;
      shift_reg <= SHIFT_RST;
      tx_cnt_reg <= TX_CNT_RST;
      tx_reg <= 8'h00;
      sda_out_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      rd_take_reg <= 1'b0;
      pend_reg <= 1'b0;
      pend_word_reg <= WORD_RST;
    end else begin
      state_reg <= state_next;
      mode3_reg <= mode3_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_reg <= tx_next;
      sda_out_reg <= sda_out_next;
      sda_oe_reg <= sda_oe_next;
      rd_take_reg <= rd_take_next;
      pend_reg <= pend_next;
      pend_word_reg <= pend_word_next;
    end
  end

  assign SDA_OUT = sda_out_reg;
  assign SDA_OE = sda_oe_reg;
  assign RD_TAKE = rd_take_reg;

  // ==========================================================
  // Busy and received-word buffer
  // ==========================================================
  logic busy_reg, busy_next;

  always_comb begin
    busy_next = WAVE_ACTIVE || TSENS_ACTIVE; // RL6
  end

  always_ff @(posedge MCLK) begin
    if (srst) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
    end
  end

  assign BUSY = busy_reg;

  eps_buf u_buf (
    .clk(MCLK),
    .srst(srst),
    .in_valid(pend_reg),
    .in_ready(buf_ready),
    .in_word(pend_word_reg),
    .out_valid(RX_VALID),
    .out_ready(RX_READY),
    .out_word(RX_WORD)
  );

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (srst);

  busy_follow_a: assert property ((WAVE_ACTIVE || TSENS_ACTIVE) |=> BUSY) // RL6
    else $error("busy not raised for waveform or sensor activity");
  cs_discard_a: assert property (link_s_reg.cs_n |=> state_reg == ST_IDLE && cnt_reg == BIT_CNT_RST) // RL12
    else $error("partial frame kept after chip select rise");
  cs_release_a: assert property (link_s_reg.cs_n |=> !SDA_OE ##1 !SDA_OE) // RL1
    else $error("data line driven while deselected");
  hw_reset_a: assert property (@(posedge MCLK) disable iff (!RST_N) !hwr_s_reg |=> !SDA_OE && !BUSY && !pend_reg) // RL4
    else $error("port active during hardware reset");
  cmd_byte_a: assert property (complete && !mode3_reg && !link_s_reg.dc |=> pend_reg && !pend_word_reg.is_data) // RL3
    else $error("four-wire command byte marked as data");
  data_byte_a: assert property (complete && !mode3_reg && link_s_reg.dc |=> pend_reg && pend_word_reg.is_data) // RL2
    else $error("four-wire data byte marked as command");
  width_four_a: assert property (complete && !mode3_reg |-> cnt_reg == 4'h7) // RL7
    else $error("four-wire unit not eight bits");
  width_three_a: assert property (complete && mode3_reg |-> cnt_reg == 4'h8) // RL8
    else $error("three-wire unit not nine bits");
  select_bit_a: assert property (complete && mode3_reg |=> pend_word_reg.is_data == $past(shift_reg[7])) // RL10
    else $error("three-wire select bit misplaced");
  msb_first_a: assert property (complete |=> pend_word_reg.data == {$past(shift_reg[6:0]), $past(link_s_reg.sda)}) // RL9
    else $error("received byte not MSB first");
  read_msb_a: assert property (fall && state_reg == ST_READ && tx_cnt_reg == 3'h0 && !link_s_reg.cs_n
    |=> SDA_OE && SDA_OUT == $past(RD_DATA[7]) && RD_TAKE) // RL11
    else $error("read byte not started with its top bit");

  four_wire_c: cover property (complete && !mode3_reg);
  three_wire_c: cover property (complete && mode3_reg);
  read_back_c: cover property (state_reg == ST_READ && fall);
  buf_full_c: cover property (pend_reg && !buf_ready);

endmodule
`default_nettype wire

/* File: verification/eps_host.sv */
// Host model of the serial link.
// Assumes a 4 ns clock; six cycles per level give a 48 ns link period.
`timescale 1ns/100ps
`default_nettype none
module eps_host (
  input wire logic clk,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic busy,
  output eps_pkg::eps_link_t link
);
  import eps_pkg::*;
  initial link = LINK_RST;
  // ==========
  // Link tasks
  task automatic half();
    repeat (6) @(posedge clk);
  endtask
  task automatic open_frame();
    while (busy !== 1'b0) @(posedge clk);
    link.cs_n <= 1'b0;
    half();
  endtask
  task automatic close_frame();
    half();
    link.cs_n <= 1'b1;
    link.sda <= ~link.sda;
    repeat (4) @(posedge clk);
  endtask
  task automatic bit_out(input logic b);
    link.sda <= b;
    half();
    link.scl <= 1'b1;
    half();
    link.scl <= 1'b0;
  endtask
  task automatic unit(input logic three, input logic kind, input logic [7:0] d, input int n);
    link.dc <= kind & ~three;
    if (three) bit_out(kind);
    for (int i = 7; i > 7 - n; i--) bit_out(d[i]);
  endtask
  // Released line reads as the inverse of the host's last bit
  task automatic rd_byte(output logic [7:0] d);
    link.dc <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      half();
      d[i] = sda_oe ? sda_out : ~link.sda;
      link.scl <= 1'b1;
      half();
      link.scl <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: verification/epaper_host_serial_port_tb.sv */
// Bench for the host serial port; the bench plays core and consumer.
// Assumes eps_host on the link; expectations kept in queues.
`timescale 1ns/100ps
`default_nettype none
module epaper_host_serial_port_tb;
  import eps_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hw_n = 1'b1;
  logic strap = 1'b0, wave = 1'b0, tsens = 1'b0, rd_en = 1'b0;
  logic rx_ready = 1'b0, stall = 1'b0, busy_run = 1'b0, busy_exp = 1'b0;
  logic [7:0] rd_data = 8'hC3;
  logic [7:0] rb;
  logic sda_out, sda_oe, busy, rd_take, rx_valid;
  eps_word_t rx_word;
  eps_link_t link;
  eps_word_t exp_q[$];
  logic [7:0] rd_q[$];
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 32'h75FE4BC5;
  eps_port dut (.MCLK(mclk), .RST_N(rst_n), .HW_RESET_N(hw_n), .BUS_MODE_STRAP(strap), .LINK(link),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .BUSY(busy), .WAVE_ACTIVE(wave), .TSENS_ACTIVE(tsens), .RD_EN(rd_en),
    .RD_DATA(rd_data), .RD_TAKE(rd_take), .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_WORD(rx_word));
  eps_host host (.clk(mclk), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy), .link(link));
  initial begin
    forever #2 mclk = ~mclk;
  end
  // ==========
  // Tasks
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic conclude();
    $display("Mismatches %0d, checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic send(input logic three, input logic kind, input logic [7:0] d);
    // Expectation first: the word can reach the consumer before the unit task returns
    exp_q.push_back('{is_data: kind, data: d});
    host.unit(three, kind, d, 8);
  endtask
  task automatic frame(input logic three, input int n);
    strap <= three;
    repeat (4) @(posedge mclk);
    host.open_frame();
    for (int i = 0; i < n; i++) send(three, i < 2 ? i[0] : 1'($random(seed)), 8'($random(seed)));
    host.close_frame();
  endtask
  task automatic rd_frame(input logic three, input logic [7:0] cmd);
    strap <= three;
    rd_en <= 1'b1;
    repeat (4) @(posedge mclk);
    host.open_frame();
    send(three, 1'b0, cmd);
    rd_en <= 1'b0;
    if (three) host.bit_out(1'b1);
    repeat (2) begin
      host.rd_byte(rb);
      check(rd_q.size() > 0 && rb === rd_q[0], "read byte");
      void'(rd_q.pop_front());
    end
    host.close_frame();
    repeat (4) @(posedge mclk);
    check(sda_oe === 1'b0, "data line still driven");
    rd_q.delete();
  endtask
  // ==========
  // Core side and consumer
  always @(posedge mclk) begin
    cyc++;
    if (rst_n) check(busy === busy_exp, "busy level");
    busy_exp = wave | tsens;
    wave <= busy_run & 1'($random(seed));
    tsens <= busy_run & 1'($random(seed));
    if (rd_take === 1'b1) begin
      rd_q.push_back(rd_data);
      rd_data <= 8'($random(seed));
    end
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      check(exp_q.size() > 0 && rx_word === exp_q[0], "received word");
      void'(exp_q.pop_front());
    end
    rx_ready <= stall ? 1'b0 : 1'($random(seed));
    if (cyc > 20000) begin
      check(1'b0, "timeout");
      conclude();
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    for (int m = 0; m < 2; m++) frame(m[0], 5);
    rd_frame(1'b0, 8'h2F);
    rd_frame(1'b1, 8'h1B);
    host.open_frame();
    host.unit(strap, 1'b1, 8'hA5, 5);
    host.close_frame();
    host.unit(1'b0, 1'b0, 8'h3C, 8);
    stall <= 1'b1;
    frame(1'b0, 1);
    host.open_frame();
    host.unit(1'b0, 1'b1, 8'h5A, 6);
    hw_n <= 1'b0;
    repeat (6) @(posedge mclk);
    check(rx_valid === 1'b0 && sda_oe === 1'b0 && busy === 1'b0, "reset outputs");
    exp_q.delete();
    hw_n <= 1'b1;
    repeat (6) @(posedge mclk);
    host.close_frame();
    stall <= 1'b0;
    frame(1'b1, 1);
    stall <= 1'b1;
    frame(1'b0, 3);
    check(rx_valid === 1'b1, "word lost in stall");
    stall <= 1'b0;
    busy_run <= 1'b1;
    repeat (100) @(posedge mclk);
    busy_run <= 1'b0;
    repeat (4) @(posedge mclk);
    check(exp_q.size() == 0, "words missing");
    conclude();
  end
endmodule
`default_nettype wire
